// >>> core/scc_defs.svh
// Constant definitions for the serial controller clock and chip-select timing block
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// Field positions inside the word format input
`define SCC_PHASE_BIT        16
`define SCC_POL_BIT          17
`define SCC_PRESCALE_MSB     15
`define SCC_PRESCALE_LSB     8

// Word layout
`define SCC_WORD_BITS        16
`define SCC_LAST_EDGE        5'h1f

// Timing counts in bus clock cycles
`define SCC_SETUP_EXTRA      10'h002
`define SCC_SETUP_KEEP_EXTRA 10'h003
`define SCC_RELEASE_EXTRA    10'h001
`define SCC_PS0_PERIOD       9'h002

// Least serial clock period that software must keep, and the smallest safe prescale
`define SCC_CLK_PERIOD_NS      8
`define SCC_MIN_SCLK_PERIOD_NS 25
`define SCC_MIN_PRESCALE ((`SCC_MIN_SCLK_PERIOD_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS - 1)

`endif

// >>> core/scc_pkg.sv
// Types and shared arithmetic for the serial controller timing block
`include "scc_defs.svh"

package scc_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SHIFT, ST_HOLD} scc_state_t;
    typedef logic [17:0] scc_fmt_t;   // Word format field group
    typedef logic [15:0] scc_word_t;  // One transfer word
    typedef logic [7:0]  scc_cnt8_t;  // Delay counts and prescale
    typedef logic [8:0]  scc_len_t;   // Serial clock period in bus cycles

    // Serial clock period in bus cycles from the prescale value
    function automatic scc_len_t scc_period_len(input scc_cnt8_t ps);
        scc_len_t len;
        len = (ps == 8'h00) ? `SCC_PS0_PERIOD : ({1'b0, ps} + 9'h001);
        return len;
    endfunction : scc_period_len

endpackage : scc_pkg

// >>> core/scc_div_if.sv
// Link between the sequencer and the serial clock half-period divider
`timescale 1ns/1ps

interface scc_div_if;
    logic            run;     // Divider counts while high
    logic [8:0]      half_a;  // First half length
    logic [8:0]      half_b;  // Second half length
    logic            tick;    // One-cycle strobe: toggle the clock now

    modport ctl (output run, output half_a, output half_b, input tick);
    modport div (input run, input half_a, input half_b, output tick);
endinterface : scc_div_if

// >>> core/scc_clk_div.sv
// Half-period divider that strobes each serial clock toggle after the first, which comes from the setup countdown
`timescale 1ns/1ps

module scc_clk_div (
    // Clock, reset, enable
    input  wire logic CLK_SYS_IN,
    input  wire logic RST_N_IN,
    input  wire logic CE_IN,
    // Sequencer link
    scc_div_if.div    dv
);
    import scc_pkg::*;

    logic [8:0] cnt_ff;      // Cycles spent in current half
    logic       sel_ff;      // Which half is running
    logic [8:0] half_len;    // Length of current half
    logic       last_cycle;  // Final cycle of current half

    // Halves alternate so odd periods split as evenly as possible
    assign half_len   = sel_ff ? dv.half_b : dv.half_a;
    assign last_cycle = (cnt_ff == (half_len - 9'h001));
    assign dv.tick    = dv.run & last_cycle;

    // Counter restarts from the first half whenever the run is dropped
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            cnt_ff <= 9'h000;
            sel_ff <= 1'b0;
        end else if (CE_IN) begin
            if (!dv.run) begin
                cnt_ff <= 9'h000;
                sel_ff <= 1'b0;
            end else if (last_cycle) begin
                cnt_ff <= 9'h000;
                sel_ff <= ~sel_ff;
            end else begin
                cnt_ff <= cnt_ff + 9'h001;
            end
        end
    end

endmodule : scc_clk_div

// >>> core/scc_ctrl_top.sv
// Controller-side serial port: clock generation, phase, polarity and chip-select timing
`timescale 1ns/1ps

module scc_ctrl_top (
    // Clock, reset, enable
    input  wire logic              CLK_SYS_IN,
    input  wire logic              RST_N_IN,
    input  wire logic              CE_IN,
    // Configuration
    input  wire logic              CTRL_SEL_IN,
    input  wire scc_pkg::scc_fmt_t WORD_FORMAT_IN,
    input  wire scc_pkg::scc_cnt8_t CS_TO_CLK_DELAY_IN,
    input  wire scc_pkg::scc_cnt8_t CLK_TO_CS_DELAY_IN,
    input  wire logic              CS_KEEP_ACTIVE_IN,
    // Word request and answer
    input  wire logic              START_IN,
    input  wire scc_pkg::scc_word_t TX_WORD_IN,
    output logic                   READY_OUT,
    output logic                   DONE_OUT,
    output scc_pkg::scc_word_t     RX_WORD_OUT,
    // Serial pins
    output logic                   SERIAL_CLK_OUT,
    output logic                   SERIAL_CLK_OE_N_OUT,
    output logic                   CTRL_OUT_DATA_OUT,
    output logic                   CTRL_OUT_DATA_OE_N_OUT,
    input  wire logic              PERIPH_OUT_DATA_IN,
    output logic                   CS_N_OUT
);
    import scc_pkg::*;

    scc_div_if dv ();

    scc_state_t state_ff, nxt_state;  // Sequencer state
    logic [9:0] cnt_ff, nxt_cnt;      // Setup and release countdown
    logic [4:0] edge_ff, nxt_edge;    // Index of the next clock edge
    logic       sclk_ff, nxt_sclk;    // Serial clock level
    logic       cs_n_ff, nxt_cs_n;    // Chip select, low active
    logic       dout_ff, nxt_dout;    // Outgoing data bit
    scc_word_t  shift_ff, nxt_shift;  // Outgoing word
    scc_word_t  rx_ff, nxt_rx;        // Incoming word
    logic       done_ff, nxt_done;    // Word finished strobe
    logic       oe_n_ff;              // Pin drive enable, low active
    logic       din_meta_ff;          // Synchroniser first stage
    logic       din_sync_ff;          // Synchroniser second stage
    // Configuration caught at the start of a word
    logic       pha_lat_ff, pol_lat_ff, keep_lat_ff;
    scc_len_t   n_lat_ff;
    scc_cnt8_t  c2t_lat_ff, t2c_lat_ff;

    // Field decode
    wire        fmt_pha   = WORD_FORMAT_IN[`SCC_PHASE_BIT];
    wire        fmt_pol   = WORD_FORMAT_IN[`SCC_POL_BIT];
    wire scc_cnt8_t fmt_ps = WORD_FORMAT_IN[`SCC_PRESCALE_MSB:`SCC_PRESCALE_LSB];
    wire scc_len_t fmt_n  = scc_period_len(fmt_ps);
    wire [9:0]  setup_len = {2'b00, CS_TO_CLK_DELAY_IN}
                          + (CS_KEEP_ACTIVE_IN ? `SCC_SETUP_KEEP_EXTRA : `SCC_SETUP_EXTRA);
    wire [8:0]  half_a    = {1'b0, n_lat_ff[8:1]};
    wire [9:0]  hold_len  = {1'b0, half_a} + {2'b00, t2c_lat_ff} + `SCC_RELEASE_EXTRA;
    wire        start_take = START_IN & READY_OUT;
    wire        edge_now  = ((state_ff == ST_SETUP) && (cnt_ff == 10'h000))
                          || ((state_ff == ST_SHIFT) && dv.tick);
    wire        leading   = ~edge_ff[0];
    wire        shift_now = (pha_lat_ff ? (leading && (edge_ff != 5'h00)) : !leading)
                          && (edge_ff != `SCC_LAST_EDGE);
    wire        sample_now = pha_lat_ff ? !leading : leading;

    // Divider link: halves of the latched period
    assign dv.run    = (state_ff == ST_SHIFT);
    assign dv.half_a = half_a;
    assign dv.half_b = n_lat_ff - half_a;

    scc_clk_div u_div (
        .CLK_SYS_IN (CLK_SYS_IN),
        .RST_N_IN   (RST_N_IN),
        .CE_IN      (CE_IN),
        .dv         (dv.div)
    );

    // Outputs
    assign READY_OUT              = (state_ff == ST_IDLE) && CTRL_SEL_IN;
    assign DONE_OUT               = done_ff;
    assign RX_WORD_OUT            = rx_ff;
    assign SERIAL_CLK_OUT         = sclk_ff;
    assign SERIAL_CLK_OE_N_OUT    = oe_n_ff;
    assign CTRL_OUT_DATA_OUT      = dout_ff;
    assign CTRL_OUT_DATA_OE_N_OUT = oe_n_ff;
    assign CS_N_OUT               = cs_n_ff;

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_edge  = edge_ff;
        nxt_sclk  = sclk_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_dout  = dout_ff;
        nxt_shift = shift_ff;
        nxt_rx    = rx_ff;
        nxt_done  = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                // Clock parked at the idle level
                nxt_sclk = fmt_pol;
                if (start_take) begin
                    nxt_state = ST_SETUP;
                    nxt_cs_n  = 1'b0;
                    nxt_cnt   = setup_len - 10'h001;
                    nxt_shift = TX_WORD_IN;
                    nxt_dout  = TX_WORD_IN[`SCC_WORD_BITS-1];
                    nxt_edge  = 5'h00;
                end
            end
            ST_SETUP: begin
                // Count down to the first clock edge
                if (cnt_ff != 10'h000) begin
                    nxt_cnt = cnt_ff - 10'h001;
                end
            end
            ST_SHIFT: begin
                // Edges come from the divider
            end
            ST_HOLD: begin
                // Keep select low, then release
                if (cnt_ff == 10'h000) begin
                    nxt_cs_n  = 1'b1;
                    nxt_state = ST_IDLE;
                    nxt_done  = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 10'h001;
                end
            end
        endcase
        // Common edge work: toggle, shift out, sample in
        if (edge_now) begin
            nxt_sclk  = ~sclk_ff;
            nxt_edge  = edge_ff + 5'h01;
            nxt_state = ST_SHIFT;
            if (shift_now) begin
                nxt_shift = {shift_ff[14:0], 1'b0};
                nxt_dout  = shift_ff[14];
            end
            if (sample_now) begin
                nxt_rx = {rx_ff[14:0], din_sync_ff};
            end
            if (edge_ff == `SCC_LAST_EDGE) begin
                nxt_state = ST_HOLD;
                nxt_cnt   = hold_len - 10'h001;
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 10'h000;
            edge_ff  <= 5'h00;
            sclk_ff  <= 1'b0;
            cs_n_ff  <= 1'b1;
            dout_ff  <= 1'b0;
            shift_ff <= 16'h0000;
            rx_ff    <= 16'h0000;
            done_ff  <= 1'b0;
        end else if (CE_IN) begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            edge_ff  <= nxt_edge;
            sclk_ff  <= nxt_sclk;
            cs_n_ff  <= nxt_cs_n;
            dout_ff  <= nxt_dout;
            shift_ff <= nxt_shift;
            rx_ff    <= nxt_rx;
            done_ff  <= nxt_done;
        end
    end

    // Config caught at start so mid-word edits cannot skew timing
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            pha_lat_ff  <= 1'b0;
            pol_lat_ff  <= 1'b0;
            keep_lat_ff <= 1'b0;
            n_lat_ff    <= `SCC_PS0_PERIOD;
            c2t_lat_ff  <= 8'h00;
            t2c_lat_ff  <= 8'h00;
        end else if (CE_IN && start_take) begin
            pha_lat_ff  <= fmt_pha;
            pol_lat_ff  <= fmt_pol;
            keep_lat_ff <= CS_KEEP_ACTIVE_IN;
            n_lat_ff    <= fmt_n;
            c2t_lat_ff  <= CS_TO_CLK_DELAY_IN;
            t2c_lat_ff  <= CLK_TO_CS_DELAY_IN;
        end
    end

    // Pin drive follows controller select; input pin synchronised
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            oe_n_ff     <= 1'b1;
            din_meta_ff <= 1'b0;
            din_sync_ff <= 1'b0;
        end else if (CE_IN) begin
            oe_n_ff     <= ~CTRL_SEL_IN;
            din_meta_ff <= PERIPH_OUT_DATA_IN;
            din_sync_ff <= din_meta_ff;
        end
    end

    // Checking helpers: cycles with select low, and gaps between toggles
    logic [9:0] since_cs_ff, gap_ff, prev_gap_ff;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            since_cs_ff <= 10'h000;
            gap_ff      <= 10'h000;
            prev_gap_ff <= 10'h000;
        end else if (CE_IN) begin
            since_cs_ff <= cs_n_ff ? 10'h000 : since_cs_ff + 10'h001;
            gap_ff      <= edge_now ? 10'h001 : gap_ff + 10'h001;
            if (edge_now) begin
                prev_gap_ff <= gap_ff;
            end
        end
    end

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN || !CE_IN);

    property p_ctrl_drive;
        CTRL_SEL_IN |=> !SERIAL_CLK_OE_N_OUT && !CTRL_OUT_DATA_OE_N_OUT;
    endproperty
    a_ctrl_drive: assert property (p_ctrl_drive) else $error("pins not driven in controller mode");

    property p_phase_shift;
        ($changed(dout_ff) && $past(state_ff) == ST_SHIFT) |->
            $changed(sclk_ff) && ($past(edge_ff[0]) != pha_lat_ff);
    endproperty
    a_phase_shift: assert property (p_phase_shift) else $error("data moved on wrong clock edge");

    property p_period;
        ($changed(sclk_ff) && $past(state_ff) == ST_SHIFT && $past(edge_ff) >= 5'h02) |->
            ($past(gap_ff) + $past(prev_gap_ff)) == {1'b0, n_lat_ff};
    endproperty
    a_period: assert property (p_period) else $error("serial clock period wrong");

    property p_ps_zero;
        ($changed(sclk_ff) && $past(state_ff) == ST_SHIFT && n_lat_ff == `SCC_PS0_PERIOD) |->
            $past(gap_ff) == 10'h001;
    endproperty
    a_ps_zero: assert property (p_ps_zero) else $error("two-cycle period not kept");

    property p_polarity;
        $fell(cs_n_ff) |-> sclk_ff == pol_lat_ff ##1 sclk_ff == pol_lat_ff;
    endproperty
    a_polarity: assert property (p_polarity) else $error("clock not at idle level at select");

    property p_duty;
        ($changed(sclk_ff) && $past(state_ff) == ST_SHIFT) |->
            $past(gap_ff) >= {1'b0, half_a} && $past(gap_ff) <= {1'b0, dv.half_b};
    endproperty
    a_duty: assert property (p_duty) else $error("clock half out of balance");

    property p_latch;
        $fell(cs_n_ff) |-> c2t_lat_ff == $past(CS_TO_CLK_DELAY_IN) && t2c_lat_ff == $past(CLK_TO_CS_DELAY_IN);
    endproperty
    a_latch: assert property (p_latch) else $error("delay counts not held");

    property p_setup_plain;
        ($changed(sclk_ff) && $past(state_ff) == ST_SETUP && !keep_lat_ff) |->
            since_cs_ff == ({2'b00, c2t_lat_ff} + `SCC_SETUP_EXTRA);
    endproperty
    a_setup_plain: assert property (p_setup_plain) else $error("setup delay wrong");

    property p_setup_keep;
        ($changed(sclk_ff) && $past(state_ff) == ST_SETUP && keep_lat_ff) |->
            since_cs_ff == ({2'b00, c2t_lat_ff} + `SCC_SETUP_KEEP_EXTRA);
    endproperty
    a_setup_keep: assert property (p_setup_keep) else $error("setup delay with keep wrong");

    property p_release;
        $rose(cs_n_ff) |-> $past(gap_ff) == hold_len && done_ff;
    endproperty
    a_release: assert property (p_release) else $error("select released at wrong time");

    property p_idle_clk;
        (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE) |-> sclk_ff == $past(fmt_pol);
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock moved while idle");

endmodule : scc_ctrl_top

// >>> sim/scc_periph_model.sv
// Behavioural serial peripheral that answers the controller port
`timescale 1ns/1ps

module scc_periph_model (
    // Serial pins
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        mosi_in,
    output logic             miso_out,
    // Mode and words
    input  wire logic        pol_in,
    input  wire logic        pha_in,
    input  wire logic [15:0] word_in,
    output logic [15:0]      rx_out
);
    logic [15:0] sh;  // Outgoing shift word

    // Known values at time zero
    initial begin
        miso_out = 1'b0;
        rx_out = 16'h0000;
        sh = 16'h0000;
    end

    // Load word at select; phase zero needs the first bit before any edge
    always @(negedge cs_n_in) begin
        sh = word_in;
        if (!pha_in) begin
            miso_out = sh[15];
        end
    end

    // Leading edge leaves the idle level; sample leading for phase zero, trailing for phase one
    always @(sclk_in) begin
        if (cs_n_in === 1'b0) begin
            if ((sclk_in !== pol_in) ^ pha_in) begin
                rx_out = {rx_out[14:0], mosi_in};
            end else if (pha_in) begin
                miso_out = sh[15];
                sh = {sh[14:0], 1'b0};
            end else begin
                sh = {sh[14:0], 1'b0};
                miso_out = sh[15];
            end
        end
    end

    // Released line has no pull: show the inverse so a stale bit cannot pass
    always @(posedge cs_n_in) begin
        miso_out = ~miso_out;
    end
endmodule : scc_periph_model

// >>> sim/tb_top.sv
// Self-checking bench for the serial controller timing block
`timescale 1ns/1ps
`include "scc_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
    import scc_pkg::*;

    typedef struct {int s; int a; int b; int h; logic pol; logic chk; scc_word_t tx; scc_word_t pw;} scc_note_t;

    logic       clk_sys, rst_n, ce, ctrl_sel, keep, start;   // Bench-driven controls
    scc_fmt_t   word_fmt;                                   // Format field group
    scc_cnt8_t  c2t, t2c;                                   // Delay counts
    scc_word_t  tx_word, rx_word, p_word, p_rx;             // Words both ways
    logic       ready, done, sclk, sclk_oe_n, mosi, mosi_oe_n, miso, cs_n;
    wire        sclk_w, mosi_w;                             // Resolved pin levels
    scc_note_t  notes[$];                                   // Expected results, oldest first
    scc_note_t  cur;                                        // Note being built
    int         n_fail, num_checks, cyc, t0, nt;
    int         tog[64];                                    // Cycle of each clock toggle
    logic       cs_prev, sclk_prev;

    assign sclk_w = sclk_oe_n ? 1'bz : sclk;
    assign mosi_w = mosi_oe_n ? 1'bz : mosi;

    scc_ctrl_top uut (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .CE_IN(ce), .CTRL_SEL_IN(ctrl_sel),
        .WORD_FORMAT_IN(word_fmt), .CS_TO_CLK_DELAY_IN(c2t), .CLK_TO_CS_DELAY_IN(t2c),
        .CS_KEEP_ACTIVE_IN(keep), .START_IN(start), .TX_WORD_IN(tx_word), .READY_OUT(ready),
        .DONE_OUT(done), .RX_WORD_OUT(rx_word), .SERIAL_CLK_OUT(sclk), .SERIAL_CLK_OE_N_OUT(sclk_oe_n),
        .CTRL_OUT_DATA_OUT(mosi), .CTRL_OUT_DATA_OE_N_OUT(mosi_oe_n), .PERIPH_OUT_DATA_IN(miso),
        .CS_N_OUT(cs_n));

    scc_periph_model peer (.sclk_in(sclk_w), .cs_n_in(cs_n), .mosi_in(mosi_w), .miso_out(miso),
        .pol_in(word_fmt[`SCC_POL_BIT]), .pha_in(word_fmt[`SCC_PHASE_BIT]), .word_in(p_word), .rx_out(p_rx));

    // Bus clock, 8 ns period
    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;

    // Verdict and end of run
    task final_report();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // Bounded wait, called at a falling edge
    task wait_ready();
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 20000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 20000) begin
            n_fail++;
        end
    endtask : wait_ready

    // Set the format once idle; expected timing worked out here
    task cfg(input int ps, input logic pha, input logic pol, input logic kp, input int c, input int t);
        int n;
        @(negedge clk_sys);
        wait_ready();
        @(posedge clk_sys);
        word_fmt <= {pol, pha, ps[7:0], 8'($urandom)};
        c2t <= c[7:0];
        t2c <= t[7:0];
        keep <= kp;
        n = (ps == 0) ? 2 : ps + 1;
        cur.a = n / 2;
        cur.b = n - cur.a;
        cur.s = c + 2 + int'(kp);
        cur.h = cur.a + t + 1;
        cur.pol = pol;
        cur.chk = (ps >= 5) && (pha || cur.s >= 3);
        // Idle clock takes the new polarity one edge late; settle it before select falls
        @(posedge clk_sys);
    endtask : cfg

    // One word; start stays high into the next call for back to back words
    task send(input logic last);
        cur.tx = scc_word_t'($urandom);
        cur.pw = scc_word_t'($urandom);
        tx_word <= cur.tx;
        start <= 1'b1;
        @(negedge clk_sys);
        p_word = cur.pw;
        wait_ready();
        @(posedge clk_sys);
        notes.push_back(cur);
        if (last) begin
            start <= 1'b0;
        end
    endtask : send

    // Output watcher: measures edges and settles the oldest note at each done pulse
    always @(negedge clk_sys) begin : mon
        scc_note_t n;
        int bad;
        cyc++;
        if (cs_prev === 1'b1 && cs_n === 1'b0) begin
            t0 = cyc;
            nt = 0;
        end
        if (sclk !== sclk_prev) begin
            if (cs_n === 1'b0) begin
                if (nt < 64) tog[nt] = cyc;
                nt++;
            end else if (rst_n === 1'b1) begin
                `CHK(sclk, word_fmt[`SCC_POL_BIT])
            end
        end
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else begin
                n = notes.pop_front();
                bad = 0;
                for (int i = 1; i < 32; i++) begin
                    if (tog[i] - tog[i-1] != ((i % 2) ? n.a : n.b)) bad++;
                end
                `CHK(nt, 32)
                `CHK(tog[0] - t0, n.s)
                `CHK(tog[2] - tog[0], n.a + n.b)
                `CHK(bad, 0)
                `CHK(cyc - tog[31], n.h)
                `CHK(cs_n, 1'b1)
                `CHK(sclk, n.pol)
                `CHK(p_rx, n.tx)
                if (n.chk) `CHK(rx_word, n.pw)
            end
        end
        cs_prev = cs_n;
        sclk_prev = sclk;
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        int ps_tab[9];
        int k;
        ps_tab = '{0, 1, 5, 6, 7, 9, 12, 5, 255};
        {rst_n, ctrl_sel, keep, start, cyc, n_fail, num_checks} = '0;
        {word_fmt, c2t, t2c, tx_word, p_word} = '0;
        ce = 1'b1;
        cs_prev = 1'b1;
        sclk_prev = 1'b0;
        void'($urandom(49));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        start <= 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(cs_n, 1'b1)
        `CHK(ready, 1'b0)
        `CHK(sclk_oe_n, 1'b1)
        @(posedge clk_sys);
        start <= 1'b0;
        ctrl_sel <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(sclk_oe_n, 1'b0)
        `CHK(mosi_oe_n, 1'b0)
        // Enable low freezes the sequencer: a standing request must not be taken
        @(posedge clk_sys);
        ce <= 1'b0;
        start <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(cs_n, 1'b1)
        @(posedge clk_sys);
        ce <= 1'b1;
        start <= 1'b0;
        // Every phase, polarity and keep setting, back to back pairs, delay extremes on the next to last pass
        for (int i = 0; i < 9; i++) begin
            if (i == 7) cfg(ps_tab[i], 1'b1, 1'b1, 1'b1, 255, 255);
            else cfg(ps_tab[i], i[1], i[0], i[2], $urandom_range(15), $urandom_range(15));
            send(1'b0);
            send(1'b1);
        end
        k = 0;
        while (notes.size() > 0 && k < 20000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 20000) n_fail++;
        final_report();
    end
endmodule : tb_top
